// >>> scc_cfg.svh
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// ****************************************
// crc
// ****************************************
`define SCC_CRC_POLY 8'h2F
`define SCC_CRC_SEED_FULL 8'hFF
`define SCC_CRC_SEED_HI 4'hF

// ****************************************
// frame layout
// ****************************************
`define SCC_FRAME_BITS 6'h20
`define SCC_BITCNT_MAX 6'h3F
`define SCC_ST_INIT 2'h0
`define SCC_ST_NORMAL 2'h1
`define SCC_ST_SELFTEST 2'h2
`define SCC_ST_ERROR 2'h3
`define SCC_SF_SPI_ERR 2'h3
`define SCC_PIN_RST 3'h2

// ****************************************
// controller registers and timing
// ****************************************
`define SCC_REG_CFG 5'h00
`define SCC_REG_CMD 5'h04
`define SCC_REG_RXD 5'h08
`define SCC_REG_STAT 5'h0C
`define SCC_REG_MASK 5'h10
`define SCC_STAT_BUSY 8
`define SCC_RESP_OKAY 2'h0
`define SCC_RESP_SLVERR 2'h2
`define SCC_CLK_NS 10
`define SCC_SCLK_HALF_NS 60
`define SCC_HALF_CYC ((`SCC_SCLK_HALF_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)

`endif

// >>> scc_pkg.sv
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_RSP_RSVD = 2'b00,
    SCC_RSP_DATA = 2'b01,
    SCC_RSP_ERR = 2'b10
  } scc_rsp_t;

  typedef enum logic [2:0] {
    SCC_H_IDLE = 3'b000,
    SCC_H_LEAD = 3'b001,
    SCC_H_HIGH = 3'b010,
    SCC_H_LOW = 3'b011,
    SCC_H_TRAIL = 3'b100,
    SCC_H_GAP = 3'b101
  } scc_hstate_t;

endpackage

// >>> scc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scc_link_if;
  logic sclk;
  logic csB;
  logic mosi;
  logic misoOut;
  logic misoOe;
  logic miso;

  // undriven line floats high
  assign miso = misoOe ? misoOut : 1'b1;

  modport dev (input sclk, input csB, input mosi, output misoOut, output misoOe);
  modport host (output sclk, output csB, output mosi, input miso);
endinterface
`default_nettype wire

// >>> scc_crc8.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_cfg.svh"
module scc_crc8
  import scc_pkg::*;
(
  input wire logic [3:0] seedNibble,
  input wire logic [31:0] dataIn,
  output logic [7:0] remainder
);
  always_comb
  begin
    remainder = (seedNibble == 4'h0) ? `SCC_CRC_SEED_FULL : {`SCC_CRC_SEED_HI, seedNibble};
    for (int i = 31; i >= 0; i--)
    begin
      // message bits enter at the lsb, so a trailing crc leaves zero behind
      if (remainder[7])
        remainder = {remainder[6:0], dataIn[i]} ^ `SCC_CRC_POLY;
      else
        remainder = {remainder[6:0], dataIn[i]};
    end
  end
endmodule
`default_nettype wire

// >>> scc_dev.sv
// How it works
// - data request: bit0 set, source, zeros, crc
// - answer: echo, status, value, detail, crc
// - 16-bit mode fills the resolution bits
// - six even nibbles are reserved, answered next
// - reserved answer undefined except crc byte
// - crc over the 24 command bits, msb first
// - bad crc: no execution, error answer
// - seed, shift message and crc, expect zero
// - polynomial x8+x5+x3+x2+x+1 for any seed
// - zero nibble gives FF, else F and nibble
// - status 00 init 01 normal 10 test 11 err
// - value captured at select fall of answer
`timescale 1ns/1ns
`default_nettype none
`include "scc_cfg.svh"
module scc_dev
  import scc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  scc_link_if.dev link,
  input wire logic [15:0] sensorValue,
  input wire logic sixteenBit,
  input wire logic initDoneFlag,
  input wire logic selfTestActive,
  input wire logic internalError,
  input wire logic [1:0] detailedStatus,
  input wire logic [3:0] crcSeedNibble,
  output logic [2:0] dataSourceSelect,
  output logic dataReq,
  output logic cmdCrcErr,
  output logic frameErr
);

  // ****************************************
  // pin synchronisers: sclk, select, mosi
  // ****************************************
  localparam logic [2:0] PIN_RST = `SCC_PIN_RST;
  logic [2:0] pinIn;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] pin_r;
  logic [2:0] pinPrev_r;
  assign pinIn = {link.sclk, link.csB, link.mosi};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          sync1_r[gi] <= PIN_RST[gi];
          sync2_r[gi] <= PIN_RST[gi];
          sync3_r[gi] <= PIN_RST[gi];
          pin_r[gi] <= PIN_RST[gi];
          pinPrev_r[gi] <= PIN_RST[gi];
        end
        else
        begin
          sync1_r[gi] <= pinIn[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi])
            pin_r[gi] <= sync3_r[gi];
          pinPrev_r[gi] <= pin_r[gi];
        end
      end
    end
  endgenerate

  wire sclkLvl = pin_r[2];
  wire csLow = !pin_r[1];
  wire sclkRise = pin_r[2] && !pinPrev_r[2];
  wire sclkFall = !pin_r[2] && pinPrev_r[2];
  wire csFall = !pin_r[1] && pinPrev_r[1];
  wire csRise = pin_r[1] && !pinPrev_r[1];

  // ****************************************
  // state
  // ****************************************
  logic [31:0] rxShift_r;
  logic [31:0] txShift_r;
  logic [5:0] bitCnt_r;
  logic badEdge_r;
  logic misoOut_r;
  logic misoOe_r;
  scc_rsp_t rspKind_r;
  logic [3:0] echo_r;
  logic [1:0] basicStatus_r;
  logic [1:0] detailStatus_r;
  logic [2:0] dataSourceSelect_r;
  logic dataReq_r;
  logic cmdCrcErr_r;
  logic frameErr_r;

  // ****************************************
  // command check at select rise
  // ****************************************
  logic [7:0] chkRem;
  scc_crc8 u_chk (
    .seedNibble(crcSeedNibble),
    .dataIn(rxShift_r),
    .remainder(chkRem)
  );

  wire crcOk = (chkRem == 8'h00);
  wire [3:0] cmdNib = rxShift_r[31:28];
  wire frameBad = badEdge_r || sclkLvl || (bitCnt_r != `SCC_FRAME_BITS);
  wire isData = cmdNib[0];
  wire isRsvd = (cmdNib == 4'h0) || (cmdNib == 4'h2) || (cmdNib == 4'h4)
    || (cmdNib == 4'h6) || (cmdNib == 4'hA) || (cmdNib == 4'hE);
  wire reqOk = !frameBad && crcOk;

  scc_rsp_t rspKind_nxt;
  assign rspKind_nxt = !reqOk ? SCC_RSP_ERR
    : (isData && !isRsvd) ? SCC_RSP_DATA : SCC_RSP_RSVD;

  logic [1:0] basicStatus_nxt;
  assign basicStatus_nxt = internalError ? `SCC_ST_ERROR
    : selfTestActive ? `SCC_ST_SELFTEST
    : !initDoneFlag ? `SCC_ST_INIT : `SCC_ST_NORMAL;
  wire [1:0] detailStatus_nxt = internalError ? detailedStatus : 2'h0;

  // ****************************************
  // answer word built at select fall
  // ****************************************
  wire [11:0] valField = sixteenBit ? sensorValue[15:4] : sensorValue[11:0];
  wire [3:0] resField = sixteenBit ? sensorValue[3:0] : 4'h0;
  logic [23:0] rspHi;
  assign rspHi = (rspKind_r == SCC_RSP_DATA)
    ? {echo_r, basicStatus_r, valField, resField, detailStatus_r}
    : (rspKind_r == SCC_RSP_ERR)
    ? {echo_r, `SCC_ST_ERROR, 16'h0000, `SCC_SF_SPI_ERR}
    : {echo_r, 20'h00000};

  logic [7:0] genRem;
  scc_crc8 u_gen (
    .seedNibble(crcSeedNibble),
    .dataIn({rspHi, 8'h00}),
    .remainder(genRem)
  );
  wire [31:0] rspWord = {rspHi, genRem};

  // ****************************************
  // receive path
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxShift_r <= 32'h00000000;
      bitCnt_r <= 6'h00;
      badEdge_r <= 1'b0;
    end
    else if (csFall)
    begin
      bitCnt_r <= 6'h00;
      badEdge_r <= sclkLvl;
    end
    else if (csLow && sclkRise)
    begin
      rxShift_r <= {rxShift_r[30:0], pin_r[0]};
      if (bitCnt_r != `SCC_BITCNT_MAX)
        bitCnt_r <= bitCnt_r + 6'h01;
    end
  end

  // ****************************************
  // decode and status at select rise
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rspKind_r <= SCC_RSP_RSVD;
      echo_r <= 4'h0;
      basicStatus_r <= `SCC_ST_INIT;
      detailStatus_r <= 2'h0;
      dataSourceSelect_r <= 3'h0;
    end
    else if (csRise)
    begin
      rspKind_r <= rspKind_nxt;
      echo_r <= cmdNib;
      basicStatus_r <= basicStatus_nxt;
      detailStatus_r <= detailStatus_nxt;
      if (reqOk && isData)
        dataSourceSelect_r <= cmdNib[3:1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataReq_r <= 1'b0;
      cmdCrcErr_r <= 1'b0;
      frameErr_r <= 1'b0;
    end
    else
    begin
      dataReq_r <= csRise && reqOk && isData;
      cmdCrcErr_r <= csRise && !frameBad && !crcOk;
      frameErr_r <= csRise && frameBad;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txShift_r <= 32'h00000000;
      misoOut_r <= 1'b0;
      misoOe_r <= 1'b0;
    end
    else if (csFall)
    begin
      txShift_r <= rspWord;
      misoOut_r <= rspWord[31];
      misoOe_r <= 1'b1;
    end
    else if (csRise)
    begin
      misoOe_r <= 1'b0;
    end
    else if (csLow && sclkFall)
    begin
      txShift_r <= {txShift_r[30:0], 1'b0};
      misoOut_r <= txShift_r[30];
    end
  end

  assign link.misoOut = misoOut_r;
  assign link.misoOe = misoOe_r;
  assign dataSourceSelect = dataSourceSelect_r;
  assign dataReq = dataReq_r;
  assign cmdCrcErr = cmdCrcErr_r;
  assign frameErr = frameErr_r;

endmodule
`default_nettype wire

// >>> scc_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_cfg.svh"
module scc_host
  import scc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  scc_link_if.host link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq
);

  // ****************************************
  // bus slave
  // ****************************************
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r, rxData_r;
  logic [4:0] awAddr_r;
  logic [3:0] wstrb_r, crcSeedNibble_r;
  logic [23:0] cmd_r;
  logic [2:0] stat_r, mask_r;
  logic busy;

  wire doWrite = !awready_r && !wready_r && !bvalid_r;
  wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire wrCfg = doWrite && (awAddr_r == `SCC_REG_CFG);
  wire wrCmd = doWrite && (awAddr_r == `SCC_REG_CMD) && (wstrb_r == 4'hF) && !busy;
  wire wrStat = doWrite && (awAddr_r == `SCC_REG_STAT);
  wire wrMask = doWrite && (awAddr_r == `SCC_REG_MASK);
  wire wrOk = wrCfg || wrCmd || wrStat || wrMask;
  wire [4:0] rdA = araddr[4:0];
  wire rdHit = (araddr[31:5] == 27'h0) && (rdA == `SCC_REG_CFG || rdA == `SCC_REG_CMD
    || rdA == `SCC_REG_RXD || rdA == `SCC_REG_STAT || rdA == `SCC_REG_MASK);
  logic [31:0] rdMux;
  assign rdMux = (rdA == `SCC_REG_CFG) ? {28'h0, crcSeedNibble_r}
    : (rdA == `SCC_REG_CMD) ? {8'h00, cmd_r}
    : (rdA == `SCC_REG_RXD) ? rxData_r
    : (rdA == `SCC_REG_STAT) ? {23'h0, busy, 5'h00, stat_r}
    : (rdA == `SCC_REG_MASK) ? {29'h0, mask_r} : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `SCC_RESP_OKAY;
      awAddr_r <= 5'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_r)
      begin
        awready_r <= 1'b0;
        awAddr_r <= (awaddr[31:5] == 27'h0) ? awaddr[4:0] : 5'h1F;
      end
      if (wvalid && wready_r)
      begin
        wready_r <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (doWrite)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wrOk ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
      end
      if (bvalid_r && bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `SCC_RESP_OKAY;
    end
    else if (arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdMux;
      rresp_r <= rdHit ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
    end
    else if (rvalid_r && rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // spi engine
  // ****************************************
  localparam int HALF = `SCC_HALF_CYC;
  scc_hstate_t st_r;
  logic [7:0] div_r;
  logic [4:0] bit_r;
  logic [31:0] tx_r, rx_r;
  logic sclk_r, csB_r, mosi_r, done_r;
  logic m1_r, m2_r, m3_r, miso_r;
  logic [7:0] cmdCrc, rspRem;
  assign busy = (st_r != SCC_H_IDLE);
  wire halfUp = (div_r == 8'(HALF - 1));

  scc_crc8 u_gen (.seedNibble(crcSeedNibble_r), .dataIn({cmd_r, 8'h00}), .remainder(cmdCrc));
  scc_crc8 u_chk (.seedNibble(crcSeedNibble_r), .dataIn(rx_r), .remainder(rspRem));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      m1_r <= 1'b1;
      m2_r <= 1'b1;
      m3_r <= 1'b1;
      miso_r <= 1'b1;
    end
    else
    begin
      m1_r <= link.miso;
      m2_r <= m1_r;
      m3_r <= m2_r;
      if (m2_r == m3_r)
        miso_r <= m3_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= SCC_H_IDLE;
      div_r <= 8'h00;
      bit_r <= 5'h00;
      tx_r <= 32'h00000000;
      rx_r <= 32'h00000000;
      sclk_r <= 1'b0;
      csB_r <= 1'b1;
      mosi_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      div_r <= (busy && !halfUp) ? div_r + 8'h01 : 8'h00;
      case (st_r)
        SCC_H_IDLE:
          if (wrCmd)
          begin
            tx_r <= {wdata_r[23:0], 8'h00};
            csB_r <= 1'b0;
            st_r <= SCC_H_LEAD;
          end
        SCC_H_LEAD:
        begin
          tx_r[7:0] <= cmdCrc;
          csB_r <= 1'b0;
          mosi_r <= tx_r[31];
          bit_r <= 5'h00;
          if (halfUp)
          begin
            sclk_r <= 1'b1;
            st_r <= SCC_H_HIGH;
          end
        end
        SCC_H_HIGH:
          if (halfUp)
          begin
            rx_r <= {rx_r[30:0], miso_r};
            sclk_r <= 1'b0;
            tx_r <= {tx_r[30:0], 1'b0};
            mosi_r <= tx_r[30];
            bit_r <= bit_r + 5'h01;
            st_r <= (bit_r == 5'h1F) ? SCC_H_TRAIL : SCC_H_LOW;
          end
        SCC_H_LOW:
          if (halfUp)
          begin
            sclk_r <= 1'b1;
            st_r <= SCC_H_HIGH;
          end
        SCC_H_TRAIL:
          if (halfUp)
          begin
            csB_r <= 1'b1;
            st_r <= SCC_H_GAP;
          end
        SCC_H_GAP:
          if (halfUp)
          begin
            done_r <= 1'b1;
            st_r <= SCC_H_IDLE;
          end
        default:
          st_r <= SCC_H_IDLE;
      endcase
    end
  end

  // ****************************************
  // registers, sticky status, interrupt
  // ****************************************
  wire [2:0] evSet = {done_r && (rx_r[27:26] == `SCC_ST_ERROR), done_r && (rspRem != 8'h00), done_r};
  wire [2:0] evClr = wrStat ? (wdata_r[2:0] & bmask[2:0]) : 3'h0;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crcSeedNibble_r <= 4'h0;
      cmd_r <= 24'h000000;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      rxData_r <= 32'h00000000;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wrCfg)
        crcSeedNibble_r <= (crcSeedNibble_r & ~bmask[3:0]) | (wdata_r[3:0] & bmask[3:0]);
      if (wrCmd)
        cmd_r <= wdata_r[23:0];
      if (wrMask)
        mask_r <= (mask_r & ~bmask[2:0]) | (wdata_r[2:0] & bmask[2:0]);
      if (done_r)
        rxData_r <= rx_r;
      stat_r <= (stat_r & ~evClr) | evSet;
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq = irq_r;
  assign link.sclk = sclk_r;
  assign link.csB = csB_r;
  assign link.mosi = mosi_r;

endmodule
`default_nettype wire

// >>> scc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module scc_checker
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic csB,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic miso
);
  logic sclkQ_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  // ****************************************
  // rising link clock edges inside a frame
  // ****************************************
  assign cnt_nxt = csB ? 6'h00 : ((sclk && !sclkQ_r) ? cnt_r + 6'h01 : cnt_r);
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkQ_r <= 1'b0;
      cnt_r <= 6'h00;
    end
    else
    begin
      sclkQ_r <= sclk;
      cnt_r <= cnt_nxt;
    end
  end
  // ****************************************
  // link checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_SEL_FALL_IDLE: assert property ($fell(csB) |-> !sclk [*6] ##1 sclk)
    else $error("link clock not idle low for the lead time");
  AST_SEL_RISE_IDLE: assert property ($rose(csB) |-> !sclk)
    else $error("link clock high at select release");
  AST_SEL_GAP: assert property ($rose(csB) |-> csB [*6])
    else $error("select gap too short");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("link clock high phase not six cycles");
  AST_BIT_COUNT: assert property ($rose(csB) |-> cnt_r == 6'h20)
    else $error("frame does not hold 32 clock edges");
  AST_MOSI_STABLE: assert property (sclk |-> $stable(mosi))
    else $error("command line moved while clock high");
  AST_MISO_STABLE: assert property (sclk && misoOe && $past(misoOe) |->
    $stable(misoOut) && (miso == misoOut))
    else $error("answer line moved while clock high");
  AST_OE_ON: assert property ($fell(csB) |-> ##[1:6] misoOe)
    else $error("answer line not driven after select");
  AST_OE_OFF: assert property (csB [*8] |-> !misoOe)
    else $error("answer line driven while not selected");
endmodule
`default_nettype wire

// >>> test_sensor_spi_command_crc.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_cfg.svh"
module test_sensor_spi_command_crc;
  logic ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, irq, mask, sixteenBit, initDoneFlag, selfTestActive, internalError;
  logic dataReq, cmdCrcErr, frameErr;
  logic [31:0] awaddr, wdata, araddr, rdata, misoW, mosiW, mosiLast, misoLast, rx, st, d;
  logic [3:0] wstrb, crcSeedNibble, hostSeed, prev, nib;
  logic [1:0] bresp, rresp, detailedStatus, r;
  logic [15:0] sensorValue;
  logic [2:0] dataSourceSelect;
  logic [3:0] nibs [14] = '{4'h1, 4'h0, 4'h3, 4'h2, 4'h5, 4'h4, 4'h7, 4'h6, 4'h9, 4'hA, 4'hB,
    4'hE, 4'hD, 4'hF};
  int checks, failures, reqCnt, crcCnt, frmCnt, reqExp;
  scc_link_if link();
  scc_dev i_scc_dev(.ref_clk(ref_clk), .rst_b(rst_b), .link(link), .sensorValue(sensorValue),
    .sixteenBit(sixteenBit), .initDoneFlag(initDoneFlag), .selfTestActive(selfTestActive),
    .internalError(internalError), .detailedStatus(detailedStatus),
    .crcSeedNibble(crcSeedNibble), .dataSourceSelect(dataSourceSelect), .dataReq(dataReq),
    .cmdCrcErr(cmdCrcErr), .frameErr(frameErr));
  scc_host i_scc_host(.ref_clk(ref_clk), .rst_b(rst_b), .link(link), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq));
  scc_checker i_scc_checker(.ref_clk(ref_clk), .rst_b(rst_b), .sclk(link.sclk),
    .csB(link.csB), .mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe),
    .miso(link.miso));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // wire and event monitors
  // ****************************************
  always @(posedge link.sclk)
    if (!link.csB)
    begin
      mosiW = {mosiW[30:0], link.mosi};
      misoW = {misoW[30:0], link.miso};
    end
  always @(posedge link.csB)
  begin
    mosiLast = mosiW;
    misoLast = misoW;
  end
  always @(negedge ref_clk)
    if (rst_b)
    begin
      reqCnt += (dataReq === 1'b1);
      crcCnt += (cmdCrcErr === 1'b1);
      frmCnt += (frameErr === 1'b1);
    end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] crc8(input logic [3:0] sn, input logic [23:0] m);
    logic [7:0] c;
    logic fb;
    c = (sn == 4'h0) ? 8'hFF : {4'hF, sn};
    for (int i = 31; i >= 0; i--)
    begin
      fb = (i >= 8) ? m[i - 8] : 1'b0;
      c = {c[6:0], fb} ^ (c[7] ? 8'h2F : 8'h00);
    end
    return c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] e);
    logic pa, pw, ta, tw, bv;
    awaddr <= {27'h0000000, a};
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    bv = 1'b0;
    while (pa || pw)
    begin
      @(negedge ref_clk);
      ta = awready;
      tw = wready;
      @(posedge ref_clk);
      if (pa && ta) awvalid <= 1'b0;
      if (pw && tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    while (!bv)
    begin
      @(negedge ref_clk);
      bv = bvalid;
      e = bresp;
      @(posedge ref_clk);
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ta, rv;
    araddr <= {27'h0000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    ta = 1'b0;
    rv = 1'b0;
    while (!ta)
    begin
      @(negedge ref_clk);
      ta = arready;
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    while (!rv)
    begin
      @(negedge ref_clk);
      rv = rvalid;
      v = rdata;
      e = rresp;
      @(posedge ref_clk);
    end
  endtask
  // one frame: send the command, wait for done, fetch the answer, clear the status
  task automatic xfer(input logic [3:0] n);
    wr(`SCC_REG_CMD, {8'h00, n, 20'h00000}, r);
    st = 32'h0;
    while (st[0] !== 1'b1) rd(`SCC_REG_STAT, st, r);
    chk(mosiLast, {n, 20'h00000, crc8(hostSeed, {n, 20'h00000})});
    chk({31'h0, irq}, {31'h0, mask});
    rd(`SCC_REG_RXD, rx, r);
    chk(rx, misoLast);
    wr(`SCC_REG_STAT, 32'h7, r);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, sixteenBit} = 6'h00;
    {initDoneFlag, selfTestActive, internalError, mask} = 4'h0;
    {awaddr, wdata, araddr} = 96'h0;
    {wstrb, crcSeedNibble, hostSeed, detailedStatus, sensorValue} = 30'h0;
    rst_b = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(`SCC_REG_CFG, d, r);
    chk(d, 32'h0);
    rd(`SCC_REG_MASK, d, r);
    chk(d, 32'h0);
    rd(5'h14, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `SCC_RESP_SLVERR});
    wr(`SCC_REG_MASK, 32'h1, r);
    mask = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      hostSeed = (m == 1) ? 4'h5 : 4'h0;
      crcSeedNibble <= hostSeed;
      sixteenBit <= m[0];
      wr(`SCC_REG_CFG, {28'h0, hostSeed}, r);
      for (int s = 0; s < 4; s++)
      begin
        initDoneFlag <= (s == 1);
        selfTestActive <= (s >= 2);
        internalError <= (s == 3);
        detailedStatus <= s[1:0] ^ 2'h1;
        xfer(4'h1);
        reqExp++;
        prev = 4'h1;
        for (int n = 0; n < 14; n++)
        begin
          nib = nibs[n];
          sensorValue <= 16'hC35A ^ {n[3:0], s[3:0], n[3:0], m[3:0]};
          xfer(nib);
          chk({24'h0, rx[7:0]}, {24'h0, crc8(hostSeed, rx[31:8])});
          if (prev[0])
          begin
            chk({8'h0, rx[31:8]}, {8'h0, prev, s[1:0], m[0] ? sensorValue[15:4] :
              sensorValue[11:0], m[0] ? sensorValue[3:0] : 4'h0,
              (s == 3) ? detailedStatus : 2'h0});
            chk({29'h0, st[2:0]}, {29'h0, s == 3, 2'h1});
          end
          else
            chk({30'h0, st[1:0]}, 32'h1);
          if (nib[0])
            chk({29'h0, dataSourceSelect}, {29'h0, nib[3:1]});
          reqExp += nib[0];
          prev = nib;
        end
      end
    end
    wr(`SCC_REG_MASK, 32'h0, r);
    mask = 1'b0;
    hostSeed = 4'h4;
    wr(`SCC_REG_CFG, 32'h4, r);
    xfer(4'h3);
    chk({31'h0, st[1]}, 32'h1);
    chk(crcCnt, 1);
    chk(reqCnt, reqExp);
    chk({29'h0, dataSourceSelect}, 32'h7);
    hostSeed = 4'h5;
    wr(`SCC_REG_CFG, 32'h5, r);
    xfer(4'h5);
    chk({8'h0, rx[31:8]}, {8'h0, 4'h3, 2'h3, 16'h0000, 2'h3});
    chk({31'h0, st[2]}, 32'h1);
    chk(frmCnt, 0);
    // a command write while a frame runs is refused
    wr(`SCC_REG_CMD, 32'h00100000, r);
    chk({30'h0, r}, {30'h0, `SCC_RESP_OKAY});
    wr(`SCC_REG_CMD, 32'h00300000, r);
    chk({30'h0, r}, {30'h0, `SCC_RESP_SLVERR});
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
